// ### design/if_tdm_serial_output.v
// Function
// (RL1) eight 16-bit converter results share four serial lines
// (RL2) each line carries up to four 16-bit slots per frame
// (RL3) bit clock is master clock divided by one, two or four; at divide-by-one the bit clock pin stands still
// (RL4) frame sync follows updates of the selected converter
// (RL5) four slot maps, each four 4-bit source fields
// (RL6) bits 11:8 of a map choose slot C of that line
// (RL7) data and sync change on rising bit clock, falling when inverted
// (RL8) style 0 gives one-bit high sync pulse before first data bit
// (RL9) style 1 toggles sync level once per frame before first bit
// (RL10) style 2 is style 0 with a sixteen-bit wide pulse
// (RL11) slower converter's last output repeats until it updates
// (RL12) receiver samples sync and data on trailing bit clock edge
// (RL13) alternate port with identical timing and its own settings
// (RL14) converter one feeds slots only when enable bit 1 is set
// (RL15) interleaved converter shows B streams equal to A streams
// (RL16) slots sent MSB first, A to D back to back after sync bit
// (RL17) slot source codes are header constants; unlisted codes send zero
`timescale 1ns/1ps
`default_nettype none
`include "if_tdm_consts.vh"

module if_tdm_serial_output (
   input  wire        clk,
   input  wire        rst_n,
   input  wire [7:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_write,
   input  wire        reg_read,
   output reg  [15:0] reg_rdata,
   input  wire        downconverter_zero_valid,
   input  wire        downconverter_zero_interleave,
   input  wire [15:0] downconverter_zero_ia,
   input  wire [15:0] downconverter_zero_qa,
   input  wire [15:0] downconverter_zero_ib,
   input  wire [15:0] downconverter_zero_qb,
   input  wire        downconverter_one_valid,
   input  wire        downconverter_one_interleave,
   input  wire [15:0] downconverter_one_ia,
   input  wire [15:0] downconverter_one_qa,
   input  wire [15:0] downconverter_one_ib,
   input  wire [15:0] downconverter_one_qb,
   output reg         source_ready,
   output wire        if_bit_clock,
   output wire        if_frame_sync,
   output wire        serial_line_zero,
   output wire        serial_line_one,
   output wire        serial_line_two,
   output wire        serial_line_three,
   output wire        alt_bit_clock,
   output wire        alt_word_select,
   output wire        alt_inphase_line_zero,
   output wire        alt_inphase_line_one,
   output wire        alt_quadrature_line_zero,
   output wire        alt_quadrature_line_one
);

   // ------------------------------------
   // decoding helpers
   // ------------------------------------

   // {hit, index}; 0..3 primary, 4..7 alternate
   function [3:0] map_decode;
      input [7:0] a;
      begin
         case (a)
            `REG_LINE0_MAP:     map_decode = 4'h8;
            `REG_LINE1_MAP:     map_decode = 4'h9;
            `REG_LINE2_MAP:     map_decode = 4'ha;
            `REG_LINE3_MAP:     map_decode = 4'hb;
            `REG_ALT_LINE0_MAP: map_decode = 4'hc;
            `REG_ALT_LINE1_MAP: map_decode = 4'hd;
            `REG_ALT_LINE2_MAP: map_decode = 4'he;
            `REG_ALT_LINE3_MAP: map_decode = 4'hf;
            default:            map_decode = 4'h0;
         endcase
      end
   endfunction

   // held = {d1 qb,ib,qa,ia, d0 qb,ib,qa,ia}
   function [15:0] slot_value;
      input [3:0]   code;
      input [127:0] held;
      begin
         case (code)
            // (RL17) source code table
            `SRC_D0_IA: slot_value = held[15:0];
            `SRC_D0_QA: slot_value = held[31:16];
            `SRC_D0_IB: slot_value = held[47:32];
            `SRC_D0_QB: slot_value = held[63:48];
            `SRC_D1_IA: slot_value = held[79:64];
            `SRC_D1_QA: slot_value = held[95:80];
            `SRC_D1_IB: slot_value = held[111:96];
            `SRC_D1_QB: slot_value = held[127:112];
            default:    slot_value = 16'h0000;
         endcase
      end
   endfunction

   // (RL6) slot A in bits 3:0 up to slot D in bits 15:12
   // (RL16) slot A lands in the top bits so it leaves first
   function [63:0] line_frame;
      input [15:0]  map;
      input [127:0] held;
      begin
         line_frame = {slot_value(map[3:0], held), slot_value(map[7:4], held),
                       slot_value(map[11:8], held), slot_value(map[15:12], held)};
      end
   endfunction

   // ------------------------------------
   // register file
   // ------------------------------------
   reg  [15:0] slot_map [0:7];
   reg  [15:0] pri_ctrl;
   reg  [15:0] alt_ctrl;
   reg  [15:0] ddc_en;
   wire [3:0]  wr_hit = map_decode(reg_addr);
   wire [5:0]  fifo_level;
   wire [1:0]  port_busy;

   // (RL5) four-nibble slot maps per line, per port
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_map[0] <= `LINE0_MAP_RESET;
         slot_map[1] <= `LINE1_MAP_RESET;
         slot_map[2] <= `LINE2_MAP_RESET;
         slot_map[3] <= `LINE3_MAP_RESET;
         slot_map[4] <= `LINE0_MAP_RESET;
         slot_map[5] <= `LINE1_MAP_RESET;
         slot_map[6] <= `LINE2_MAP_RESET;
         slot_map[7] <= `LINE3_MAP_RESET;
         pri_ctrl    <= `CTRL_RESET;
         alt_ctrl    <= `CTRL_RESET;
         ddc_en      <= `DDC_EN_RESET;
      end else if (reg_write) begin
         if (wr_hit[3]) begin
            slot_map[wr_hit[2:0]] <= reg_wdata;
         end
         case (reg_addr)
            `REG_PRI_CTRL: pri_ctrl <= reg_wdata;
            `REG_ALT_CTRL: alt_ctrl <= reg_wdata;
            `REG_DDC_EN:   ddc_en   <= reg_wdata;
            default:       ;
         endcase
      end
   end

   // data one cycle after the strobe; unmapped reads zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (!reg_read) begin
         reg_rdata <= 16'h0000;
      end else if (wr_hit[3]) begin
         reg_rdata <= slot_map[wr_hit[2:0]];
      end else begin
         case (reg_addr)
            `REG_PRI_CTRL: reg_rdata <= pri_ctrl;
            `REG_ALT_CTRL: reg_rdata <= alt_ctrl;
            `REG_DDC_EN:   reg_rdata <= ddc_en;
            `REG_STATUS:   reg_rdata <= {6'h00, port_busy, 2'h0, fifo_level};
            default:       reg_rdata <= 16'h0000;
         endcase
      end
   end

   // ------------------------------------
   // sample buffer
   // ------------------------------------
   wire         en0 = ddc_en[0];
   // (RL14) converter one only with enable bit 1
   wire         en1 = ddc_en[1];
   wire         take0 = downconverter_zero_valid & en0;
   wire         take1 = downconverter_one_valid & en1;
   // (RL15) interleaved mode mirrors A onto B
   wire [63:0]  word0 = downconverter_zero_interleave ?
                        {downconverter_zero_qa, downconverter_zero_ia,
                         downconverter_zero_qa, downconverter_zero_ia} :
                        {downconverter_zero_qb, downconverter_zero_ib,
                         downconverter_zero_qa, downconverter_zero_ia};
   wire [63:0]  word1 = downconverter_one_interleave ?
                        {downconverter_one_qa, downconverter_one_ia,
                         downconverter_one_qa, downconverter_one_ia} :
                        {downconverter_one_qb, downconverter_one_ib,
                         downconverter_one_qa, downconverter_one_ia};
   wire         fifo_in_ready;
   wire         pop_valid;
   wire [129:0] pop_data;
   wire [1:0]   pend;
   // no draining while a frame waits, so
   // a snapshot never mixes two updates
   wire         drain_ready = ~(pend[0] | pend[1]);

   word_fifo #(.WIDTH(`FIFO_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (take0 | take1),
      .in_ready  (fifo_in_ready),
      .in_data   ({take1, take0, word1, word0}),
      .out_valid (pop_valid),
      .out_ready (drain_ready),
      .out_data  (pop_data),
      .level     (fifo_level)
   );

   // registered copy: one push may still land on a full buffer and is lost
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         source_ready <= 1'b0;
      end else begin
         source_ready <= fifo_in_ready;
      end
   end

   // (RL11) each half keeps its last value until that converter updates
   // a frame snapshot in the update cycle must see the new value
   reg  [127:0] held;
   wire [127:0] next_held = {(pop_valid & pop_data[129]) ? pop_data[127:64] : held[127:64],
                             (pop_valid & pop_data[128]) ? pop_data[63:0] : held[63:0]};
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         held <= {8{16'h0000}};
      end else begin
         held <= next_held;
      end
   end

   // ------------------------------------
   // serial ports: 0 primary, 1 alternate
   // ------------------------------------
   wire [1:0] bclk_out;
   wire [1:0] sync_out;
   wire [7:0] line_out;

   genvar p;
   generate
      // (RL13) alternate port is a second copy with its own settings
      for (p = 0; p < 2; p = p + 1) begin : g_port
         reg  [1:0]  divcnt;
         reg         bclk;
         reg         fs;
         reg  [4:0]  fsrun;
         reg         busy;
         reg         pend_r;
         reg  [6:0]  bitpos;
         reg  [255:0] shreg;
         reg  [3:0]  dout;
         integer     l;
         wire [15:0] ctrl  = (p == 0) ? pri_ctrl : alt_ctrl;
         wire [1:0]  div   = ctrl[`CTL_DIV_MSB:`CTL_DIV_LSB];
         wire [1:0]  style = ctrl[`CTL_STYLE_MSB:`CTL_STYLE_LSB];
         wire        inv   = ctrl[`CTL_INV_BIT];
         // (RL3) bit period of one, two or four master clocks
         wire [1:0]  last  = (div == `DIV_BY_FOUR) ? 2'h3 :
                             (div == `DIV_BY_TWO)  ? 2'h1 : 2'h0;
         wire        tick  = (divcnt == last);
         wire [1:0]  next_divcnt = tick ? 2'h0 : divcnt + 2'h1;
         // (RL4) frame trigger from the selected converter's update
         wire        trig  = pop_valid &
                             (ctrl[`CTL_SEL_BIT] ? pop_data[129] : pop_data[128]);

         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               divcnt <= 2'h0;
               bclk   <= 1'b0;
               fs     <= 1'b0;
               fsrun  <= 5'h00;
               busy   <= 1'b0;
               pend_r <= 1'b0;
               bitpos <= 7'h00;
               shreg  <= {256{1'b0}};
               dout   <= 4'h0;
            end else begin
               divcnt <= next_divcnt;
               // (RL7) rising edge at each bit start, inverted on request;
               // divide-by-one cannot be shown from a flop and stands still
               bclk <= inv ^ ((last != 2'h0) && (next_divcnt <= (last >> 1)));
               if (trig & ~tick) begin
                  pend_r <= 1'b1;
               end else if (tick) begin
                  pend_r <= 1'b0;
               end
               if (tick & (pend_r | trig)) begin
                  // sync bit: a fresh trigger cuts off unsent slots
                  for (l = 0; l < 4; l = l + 1) begin
                     shreg[l*64 +: 64] <= line_frame(slot_map[p*4+l], next_held);
                  end
                  busy   <= 1'b1;
                  bitpos <= 7'h00;
                  dout   <= 4'h0;
                  if (style == `STYLE_TOGGLE) begin
                     // (RL9) level flips once per frame
                     fs <= ~fs;
                  end else begin
                     // (RL8) one-bit pulse ahead of first data bit
                     fs <= 1'b1;
                     // (RL10) wide style holds fifteen more bits
                     fsrun <= (style == `STYLE_WIDE) ? `WIDE_EXTRA_BITS : 5'h00;
                  end
               end else if (tick) begin
                  if (style != `STYLE_TOGGLE) begin
                     if (fsrun != 5'h00) begin
                        fsrun <= fsrun - 5'h01;
                     end else begin
                        fs <= 1'b0;
                     end
                  end
                  if (busy) begin
                     // (RL2) four slots per line then the line idles low
                     if (bitpos == `FRAME_BITS) begin
                        busy <= 1'b0;
                        dout <= 4'h0;
                     end else begin
                        // (RL1) four lines shift in parallel, MSB first
                        for (l = 0; l < 4; l = l + 1) begin
                           dout[l]           <= shreg[l*64+63];
                           shreg[l*64 +: 64] <= {shreg[l*64 +: 63], 1'b0};
                        end
                        bitpos <= bitpos + 7'h01;
                     end
                  end
               end
            end
         end

         assign bclk_out[p]         = bclk;
         assign sync_out[p]         = fs;
         assign line_out[p*4 +: 4]  = dout;
         assign port_busy[p]        = busy;
         assign pend[p]             = pend_r;
      end
   endgenerate

   // ------------------------------------
   // pins
   // ------------------------------------
   // (RL12) launch edges leave the trailing edge free for sampling
   assign if_bit_clock             = bclk_out[0];
   assign if_frame_sync            = sync_out[0];
   assign serial_line_zero         = line_out[0];
   assign serial_line_one          = line_out[1];
   assign serial_line_two          = line_out[2];
   assign serial_line_three        = line_out[3];
   assign alt_bit_clock            = bclk_out[1];
   assign alt_word_select          = sync_out[1];
   assign alt_inphase_line_zero    = line_out[4];
   assign alt_inphase_line_one     = line_out[5];
   assign alt_quadrature_line_zero = line_out[6];
   assign alt_quadrature_line_one  = line_out[7];

endmodule // if_tdm_serial_output

`default_nettype wire

// ### design/if_tdm_consts.vh
`ifndef IF_TDM_CONSTS_VH
`define IF_TDM_CONSTS_VH

// ------------------------------------
// register addresses
// ------------------------------------
`define REG_LINE0_MAP     8'h17
`define REG_LINE1_MAP     8'h18
`define REG_LINE2_MAP     8'h19
`define REG_LINE3_MAP     8'h1a
`define REG_PRI_CTRL      8'h1b
`define REG_DDC_EN        8'h1c
`define REG_STATUS        8'h1d
`define REG_ALT_LINE0_MAP 8'h20
`define REG_ALT_LINE1_MAP 8'h21
`define REG_ALT_LINE2_MAP 8'h22
`define REG_ALT_LINE3_MAP 8'h23
`define REG_ALT_CTRL      8'h24

// ------------------------------------
// control fields and reset values
// ------------------------------------
`define CTL_DIV_LSB       0
`define CTL_DIV_MSB       1
`define CTL_INV_BIT       2
`define CTL_SEL_BIT       3
`define CTL_STYLE_LSB     4
`define CTL_STYLE_MSB     5
`define CTRL_RESET        16'h0000
`define DDC_EN_RESET      16'h0003
`define LINE0_MAP_RESET   16'h3210
`define LINE1_MAP_RESET   16'h7654
`define LINE2_MAP_RESET   16'hffff
`define LINE3_MAP_RESET   16'hffff

// ------------------------------------
// divider, sync style and slot source codes
// ------------------------------------
`define DIV_BY_TWO        2'h1
`define DIV_BY_FOUR       2'h2
`define STYLE_TOGGLE      2'h1
`define STYLE_WIDE        2'h2
`define SRC_D0_IA         4'h0
`define SRC_D0_QA         4'h1
`define SRC_D0_IB         4'h2
`define SRC_D0_QB         4'h3
`define SRC_D1_IA         4'h4
`define SRC_D1_QA         4'h5
`define SRC_D1_IB         4'h6
`define SRC_D1_QB         4'h7

// ------------------------------------
// frame geometry and buffering
// ------------------------------------
`define FRAME_BITS        7'h40
`define WIDE_EXTRA_BITS   5'h0f
`define FIFO_DEPTH        32
`define FIFO_AW           5
`define FIFO_W            130

`endif

// ### design/sample_ram.v
`timescale 1ns/1ps
`default_nettype none

module sample_ram #(
   parameter WIDTH = 130,
   parameter AW    = 5
) (
   input  wire             clk,
   input  wire             wr_en,
   input  wire [AW-1:0]    wr_addr,
   input  wire [WIDTH-1:0] wr_data,
   input  wire             rd_en,
   input  wire [AW-1:0]    rd_addr,
   output reg  [WIDTH-1:0] rd_data
);

   reg [WIDTH-1:0] mem [0:(1<<AW)-1];

   // no reset: plain storage, read data registered
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule // sample_ram

`default_nettype wire

// ### design/word_fifo.v
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
   parameter WIDTH = 130,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output reg              out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data,
   output wire [AW:0]      level
);

   reg  [AW-1:0] wptr;
   reg  [AW-1:0] rptr;
   reg  [AW:0]   count;
   wire          full  = (count == DEPTH[AW:0]);
   wire          empty = (count == {(AW+1){1'b0}});
   wire          push  = in_valid & ~full;
   // read is issued now, word shows one cycle later with out_valid
   wire          pop   = out_ready & ~empty;

   assign in_ready = ~full;
   assign level    = count;

   sample_ram #(.WIDTH(WIDTH), .AW(AW)) u_ram (
      .clk     (clk),
      .wr_en   (push),
      .wr_addr (wptr),
      .wr_data (in_data),
      .rd_en   (pop),
      .rd_addr (rptr),
      .rd_data (out_data)
   );

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr      <= {AW{1'b0}};
         rptr      <= {AW{1'b0}};
         count     <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
      end else begin
         out_valid <= pop;
         if (push) begin
            wptr <= wptr + 1'b1;
         end
         if (pop) begin
            rptr <= rptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end

endmodule // word_fifo

`default_nettype wire

// ### tb/if_tdm_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// primary port timing and register read checks
// ----------------------------------------
module if_tdm_properties (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [15:0] reg_rdata,
   input wire logic        if_bit_clock,
   input wire logic        if_frame_sync,
   input wire logic        serial_line_zero
);
   logic [5:0] ctl;
   logic [3:0] quiet;
   // control shadow; checks wait for settling
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl   <= 6'h00;
         quiet <= 4'h0;
      end else if (reg_write && reg_addr == 8'h1b) begin
         ctl   <= reg_wdata[5:0];
         quiet <= 4'h0;
      end else if (quiet != 4'hf) begin
         quiet <= quiet + 4'h1;
      end
   end
   wire set = quiet > 4'h4;
   wire d1  = set && (ctl[1:0] == 2'h0 || ctl[1:0] == 2'h3);
   wire d2  = set && ctl[1:0] == 2'h1;
   wire d4  = set && ctl[1:0] == 2'h2;
   wire s0  = ctl[5:4] == 2'h0 || ctl[5:4] == 2'h3;
   // a write may retime the port, so it aborts any check in flight
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n || reg_write);
   rdata_idle_a: assert property (
      !$past(reg_read) |-> reg_rdata == 16'h0000) else $error("read data not idle");
   unmapped_zero_a: assert property (
      reg_read && reg_addr > 8'h24 |=> reg_rdata == 16'h0000) else $error("unmapped read");
   div1_flat_a: assert property (
      d1 |-> if_bit_clock == ctl[2]) else $error("divide by one clock moves");
   div2_toggle_a: assert property (
      d2 |=> if_bit_clock != $past(if_bit_clock)) else $error("half rate clock stuck");
   div4_shape_a: assert property (
      d4 && $rose(if_bit_clock) |-> if_bit_clock [*2] ##1 !if_bit_clock [*2])
      else $error("quarter rate clock shape");
   pulse_width_a: assert property (
      d2 && s0 && $rose(if_frame_sync) |-> if_bit_clock != ctl[2] ##0 if_frame_sync [*2]
      ##1 !if_frame_sync) else $error("sync pulse width or edge");
   wide_width_a: assert property (
      d1 && ctl[5:4] == 2'h2 && $rose(if_frame_sync) |-> if_frame_sync [*8] ##1
      if_frame_sync [*8] ##1 !if_frame_sync) else $error("wide sync width");
   toggle_hold_a: assert property (
      d1 && ctl[5:4] == 2'h1 && $changed(if_frame_sync) |=> $stable(if_frame_sync) [*8])
      else $error("toggle sync moved early");
   sync_bit_data_a: assert property (
      set && s0 && $rose(if_frame_sync) |-> !serial_line_zero) else $error("data in sync bit");
   cover property (d2 && $rose(if_frame_sync));
   cover property (d1 && $changed(if_frame_sync));
   cover property (reg_read && reg_addr > 8'h24);
endmodule // if_tdm_properties
`default_nettype wire

// ### tb/dsp_receiver.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far end serial receiver
// ----------------------------------------
module dsp_receiver (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [2:0]  period,
   input  wire logic        toggle_mode,
   input  wire logic        sync,
   input  wire logic [3:0]  lines,
   output var  logic [63:0] word [4],
   output var  int          frames
);
   logic [63:0] sh [4];
   logic        prev;
   logic        busy;
   int          cnt;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev   <= 1'b0;
         busy   <= 1'b0;
         frames <= 0;
      end else begin
         prev <= sync;
         if (sync !== prev && (toggle_mode || sync)) begin
            busy <= 1'b1;
            cnt  <= 1;
         end else if (busy) begin
            cnt <= cnt + 1;
            // trailing edge sample
            // last clock of each bit
            if (cnt >= period && cnt % period == period - 1) begin
               for (int i = 0; i < 4; i++) sh[i] = {sh[i][62:0], lines[i]};
            end
            if (cnt == 65 * period - 1) begin
               busy   <= 1'b0;
               word   <= sh;
               frames <= frames + 1;
            end
         end
      end
   end
endmodule // dsp_receiver
`default_nettype wire

// ### tb/if_tdm_serial_output_tb.sv
`timescale 1ns/1ps
`default_nettype none
module if_tdm_serial_output_tb;
   logic        clk, rst_n, reg_write, reg_read, v0, v1, il0, rx_t, full;
   logic        bclk, fs, abclk, aws, srdy;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [15:0] d0 [4], d1 [4], h0 [4], h1 [4];
   logic [63:0] w_p [4], w_a [4];
   logic [3:0]  ln, aln;
   logic [2:0]  rx_p;
   logic [1:0]  en;
   int          f_p, f_a, n, error_cnt, checks_done;
   logic [15:0] mp [4] = '{16'h3210, 16'h7654, 16'hf5ff, 16'h2f6f};
   logic [15:0] cfgs [7] = '{16'h0001, 16'h0000, 16'h0002, 16'h0010, 16'h0020, 16'h0005,
                             16'h0004};
   // address, reset value, written value, value read back
   logic [55:0] rows [8] = '{{8'h17, 16'h3210, 16'h1234, 16'h1234},
      {8'h18, 16'h7654, 16'habcd, 16'habcd}, {8'h19, 16'hffff, 16'h0000, 16'h0000},
      {8'h1a, 16'hffff, 16'h5555, 16'h5555}, {8'h1b, 16'h0000, 16'h0035, 16'h0035},
      {8'h1c, 16'h0003, 16'h0002, 16'h0002}, {8'h1d, 16'h0000, 16'hffff, 16'h0000},
      {8'h30, 16'h0000, 16'h1234, 16'h0000}};
   if_tdm_serial_output u_if_tdm_serial_output (.clk(clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .downconverter_zero_valid(v0),
      .downconverter_zero_interleave(il0), .downconverter_zero_ia(d0[0]),
      .downconverter_zero_qa(d0[1]), .downconverter_zero_ib(d0[2]),
      .downconverter_zero_qb(d0[3]), .downconverter_one_valid(v1),
      .downconverter_one_interleave(1'b0), .downconverter_one_ia(d1[0]),
      .downconverter_one_qa(d1[1]), .downconverter_one_ib(d1[2]),
      .downconverter_one_qb(d1[3]), .source_ready(srdy), .if_bit_clock(bclk),
      .if_frame_sync(fs), .serial_line_zero(ln[0]), .serial_line_one(ln[1]),
      .serial_line_two(ln[2]), .serial_line_three(ln[3]), .alt_bit_clock(abclk),
      .alt_word_select(aws), .alt_inphase_line_zero(aln[0]), .alt_inphase_line_one(aln[1]),
      .alt_quadrature_line_zero(aln[2]), .alt_quadrature_line_one(aln[3]));
   dsp_receiver u_dsp_receiver (.clk(clk), .rst_n(rst_n), .period(rx_p), .toggle_mode(rx_t),
      .sync(fs), .lines(ln), .word(w_p), .frames(f_p));
   dsp_receiver u_dsp_receiver_alt (.clk(clk), .rst_n(rst_n), .period(rx_p),
      .toggle_mode(rx_t), .sync(aws), .lines(aln), .word(w_a), .frames(f_a));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic give_verdict();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 chk("reg_rdata", e, reg_rdata);
   endtask
   function automatic logic [15:0] src(input logic [3:0] c);
      return c < 4 ? h0[c[1:0]] : c < 8 ? h1[c[1:0]] : 16'h0000;
   endfunction
   function automatic logic [63:0] exp_line(input logic [15:0] m);
      return {src(m[3:0]), src(m[7:4]), src(m[11:8]), src(m[15:12])};
   endfunction
   // both ports alike, one expectation serves both
   task automatic cfg(input logic [15:0] c);
      wr(8'h1b, c);
      wr(8'h24, c);
      rx_p <= c[1:0] == 2'h1 ? 3'h2 : c[1:0] == 2'h2 ? 3'h4 : 3'h1;
      rx_t <= c[5:4] == 2'h1;
      repeat (8) @(posedge clk);
   endtask
   task automatic run(input logic a, input logic b, input logic want);
      int fp, fa;
      fp = f_p;
      fa = f_a;
      n++;
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         d0[i] <= {n[7:0], 4'h0, 4'(i)};
         d1[i] <= {n[7:0], 4'h8, 4'(i)};
         if (a && en[0]) h0[i] = {n[7:0], 4'h0, 4'(i)};
         if (b && en[1]) h1[i] = {n[7:0], 4'h8, 4'(i)};
      end
      if (a && en[0] && il0) h0[2:3] = h0[0:1];
      v0 <= a;
      v1 <= b;
      @(posedge clk);
      v0 <= 1'b0;
      v1 <= 1'b0;
      for (int k = 0; k < 400 && (f_p == fp || f_a == fa); k++) @(posedge clk);
      chk("frame", 64'(want), 64'(f_p != fp));
      for (int i = 0; i < 4 && want; i++) begin
         chk("line", exp_line(mp[i]), w_p[i]);
         chk("alt_line", exp_line(mp[i]), w_a[i]);
      end
   endtask
   initial begin
      #(40000 * 10);
      error_cnt++;
      give_verdict();
   end
   initial begin
      {rst_n, reg_write, reg_read, v0, v1, il0, rx_t, full, reg_addr, reg_wdata} = '0;
      {n, error_cnt, checks_done} = '0;
      d0 = '{default: 16'h0000};
      d1 = '{default: 16'h0000};
      rx_p = 3'h1;
      en = 2'h3;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[r]) begin
         rd(rows[r][55:48], rows[r][47:32]);
         wr(rows[r][55:48], rows[r][31:16]);
         rd(rows[r][55:48], rows[r][15:0]);
      end
      wr(8'h1c, 16'h0003);
      for (int i = 0; i < 4; i++) begin
         wr(8'h17 + 8'(i), mp[i]);
         wr(8'h20 + 8'(i), mp[i]);
      end
      foreach (cfgs[c]) begin
         cfg(cfgs[c]);
         run(1'b1, 1'b1, 1'b1);
      end
      cfg(16'h0001);
      run(1'b1, 1'b0, 1'b1);
      wr(8'h1c, 16'h0001);
      en = 2'h1;
      run(1'b1, 1'b1, 1'b1);
      wr(8'h1c, 16'h0003);
      en = 2'h3;
      il0 <= 1'b1;
      run(1'b1, 1'b0, 1'b1);
      il0 <= 1'b0;
      cfg(16'h0009);
      run(1'b1, 1'b0, 1'b0);
      run(1'b0, 1'b1, 1'b1);
      cfg(16'h0002);
      @(posedge clk);
      v0 <= 1'b1;
      repeat (64) begin
         @(posedge clk);
         #1 full = full | (srdy === 1'b0);
      end
      @(posedge clk);
      v0 <= 1'b0;
      repeat (12000) @(posedge clk);
      chk("source_ready_low", 64'h1, 64'(full));
      rd(8'h1d, 16'h0000);
      give_verdict();
   end
endmodule // if_tdm_serial_output_tb
bind if_tdm_serial_output if_tdm_properties u_if_tdm_properties (.*);
`default_nettype wire
